/* shared/mds_regs.svh */
// Register offsets, field positions and reset values of the status block.
`ifndef MDS_REGS_SVH
`define MDS_REGS_SVH

// Byte offsets of the registers on the AHB-Lite register bus.
`define MDS_TX_POLL_OFF   8'h08
`define MDS_RX_POLL_OFF   8'h10
`define MDS_STATUS_OFF    8'h28
`define MDS_NAC_OFF       8'h30
`define MDS_MASK_OFF      8'h38

// Bit positions inside the interrupt status word.
`define MDS_ST_TX_COMPLETE   0
`define MDS_ST_TX_STOPPED    1
`define MDS_ST_TX_DESC_UNAV  2
`define MDS_ST_TX_JABBER     3
`define MDS_ST_RESERVED4     4
`define MDS_ST_TX_UNDERFLOW  5
`define MDS_ST_RX_COMPLETE   6
`define MDS_ST_RX_DESC_UNAV  7
`define MDS_ST_ABN_SUMMARY   15
`define MDS_ST_NRM_SUMMARY   16

// Bit positions inside the network access control word.
`define MDS_NAC_SQE_DISABLE  19
`define MDS_NAC_STORE_FWD    21

// Reset values of the control bits.
`define MDS_NAC_SQE_RESET    1'b1
`define MDS_NAC_SF_RESET     1'b0
`define MDS_MASK_RESET       8'h00

// Bit positions inside the transmit descriptor words.
`define MDS_TDW0_UNDERFLOW   1
`define MDS_TDW0_JABBER      14
`define MDS_TDW1_IRQ_REQ     31

// Width of the flag bank, bits 7 down to 0 of the status word.
`define MDS_FLAG_W           8

`endif

/* shared/mds_pkg.sv */
// Types shared by the status block modules.
package mds_pkg;

  // Process states, Gray coded along stop, run, suspended.
  typedef enum logic [1:0] {
    MDS_PROC_STOP    = 2'b00,
    MDS_PROC_RUN     = 2'b01,
    MDS_PROC_SUSPEND = 2'b11
  } mds_proc_t;

endpackage

/* design/mds_flag_bank.sv */
// Bank of sticky status flags, set by events and cleared by software ones.
`timescale 1ns/1ns
`include "mds_regs.svh"

module mds_flag_bank
(
  // Clock and reset.
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // Set events from the block and clear strobes from software.
  input  wire logic [`MDS_FLAG_W-1:0] set_evt,
  input  wire logic [`MDS_FLAG_W-1:0] clr_req,
  // Current flag values.
  output logic      [`MDS_FLAG_W-1:0] flags
);

  logic [`MDS_FLAG_W-1:0] flag_ff;

  // One sticky cell per bit; a set in the clear cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < `MDS_FLAG_W; gi = gi + 1)
    begin : g_flag
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          flag_ff[gi] <= 1'b0;
        else if (set_evt[gi])
          flag_ff[gi] <= 1'b1;
        else if (clr_req[gi])
          flag_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  assign flags = flag_ff;

endmodule // mds_flag_bank

/* design/mds_ahb_slave.sv */
// AHB-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ns

module mds_ahb_slave
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register side strobes.
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata
);

  logic        wr_ff;
  logic        rd_ff;
  logic        rd_done_ff;
  logic [7:0]  addr_ff;
  logic [31:0] hrdata_ff;
  logic        accept;

  // Only whole-word NONSEQ or SEQ transfers are taken; others are ignored.
  assign accept = hsel && hready && htrans[1] && (hsize == 3'b010);

  // Address phase capture; the data phase follows on the next cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      addr_ff <= 8'h00;
    end
    else if (hready)
    begin
      wr_ff <= accept && hwrite;
      rd_ff <= accept && !hwrite;
      if (accept)
        addr_ff <= haddr[7:0];
    end
  end

  // Reads take one wait state so the data word comes from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done_ff <= 1'b0;
      hrdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      rd_done_ff <= rd_ff && !rd_done_ff;
      if (rd_ff && !rd_done_ff)
        hrdata_ff <= reg_rdata;
    end
  end

  assign hreadyout = !(rd_ff && !rd_done_ff);
  assign hresp     = 1'b0;            // Always OKAY.
  assign hrdata    = hrdata_ff;
  assign reg_wr    = wr_ff;
  assign reg_rd    = rd_ff && !rd_done_ff;
  assign reg_addr  = addr_ff;
  assign reg_wdata = hwdata;

endmodule // mds_ahb_slave

/* design/mds_status_top.sv */
// Interrupt status flags, network access bits and process state tracking.
//
// What this block does
// - Missing receive descriptor sets status bit 7 and suspends receive.
// - Receive resumes on receive poll demand or a new recognized frame.
// - Each finished frame reception sets status bit 6.
// - Transmit underflow sets bit 5, suspends, writes descriptor word0 bit 1.
// - Jabber expiry sets bit 3, stops transmit, writes word0 bit 14.
// - Missing transmit descriptor sets status bit 2 and suspends transmit.
// - Status bit 1 is set while transmit state is stop.
// - Frame done sets bit 0 only when word1 bit 31 requested it.
// - Access bit 21, reset 0, makes transmit start ignore the threshold.
// - Access bit 19 disables SQE test when 1; resets to 1.
// - Bit 16 summarizes transmit complete, transmit unavailable, rx complete.
// - Bit 15 summarizes all abnormal flags including outside ones.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "mds_regs.svh"

module mds_status_top
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Receive engine events and commands.
  input  wire logic        rx_start_cmd,
  input  wire logic        rx_stop_cmd,
  input  wire logic        rx_desc_fetch_fail,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_frame_recognized,
  // Transmit engine events and commands.
  input  wire logic        tx_start_cmd,
  input  wire logic        tx_stop_cmd,
  input  wire logic        tx_auto_poll,
  input  wire logic        tx_desc_fetch_fail,
  input  wire logic        tx_underflow,
  input  wire logic        tx_jabber_expire,
  input  wire logic        tx_frame_done,
  input  wire logic [31:0] tx_desc_word1,
  input  wire logic        tx_threshold_met,
  input  wire logic        tx_frame_whole,
  // Abnormal flags held outside this block.
  input  wire logic        ext_abnormal,
  // Process control towards the engines.
  output logic [1:0]       rx_state,
  output logic [1:0]       tx_state,
  output logic             rx_poll_demand,
  output logic             tx_poll_demand,
  output logic             tx_begin,
  output logic             tx_desc_word0_wr,
  output logic [31:0]      tx_desc_word0,
  // Network access control bits.
  output logic             store_forward_enable,
  output logic             sqe_test_enable,
  // Interrupt.
  output logic             irq
);

  // Register bus strobes.
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;

  // Control and status state.
  mds_pkg::mds_proc_t       rx_state_ff;
  mds_pkg::mds_proc_t       tx_state_ff;
  logic                     sf_ff;
  logic                     sqe_dis_ff;
  logic [`MDS_FLAG_W-1:0]   mask_ff;
  logic                     rx_poll_ff;
  logic                     tx_poll_ff;
  logic                     tx_begin_ff;
  logic                     tdw0_wr_ff;
  logic [31:0]              tdw0_ff;

  // Flag bank wiring.
  logic [`MDS_FLAG_W-1:0]   flag_set;
  logic [`MDS_FLAG_W-1:0]   flag_clr;
  logic [`MDS_FLAG_W-1:0]   flags;
  logic                     normal_summary_flag;
  logic                     abnormal_summary_flag;

  // Decoded write strobes.
  logic                     wr_status;
  logic                     wr_nac;
  logic                     wr_mask;
  logic                     wr_tx_poll;
  logic                     wr_rx_poll;

  // Running-state shorthands.
  logic                     tx_run;
  logic                     rx_run;

  // Matches a captured bus offset against one register offset.
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  // Bus slave front end.
  mds_ahb_slave u_slave
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  // Write decode for every register.
  assign wr_status  = reg_wr && reg_hit(reg_addr, `MDS_STATUS_OFF);
  assign wr_nac     = reg_wr && reg_hit(reg_addr, `MDS_NAC_OFF);
  assign wr_mask    = reg_wr && reg_hit(reg_addr, `MDS_MASK_OFF);
  assign wr_tx_poll = reg_wr && reg_hit(reg_addr, `MDS_TX_POLL_OFF);
  assign wr_rx_poll = reg_wr && reg_hit(reg_addr, `MDS_RX_POLL_OFF);

  assign tx_run = (tx_state_ff == mds_pkg::MDS_PROC_RUN);
  assign rx_run = (rx_state_ff == mds_pkg::MDS_PROC_RUN);

  // Event sources for each sticky flag; reserved bit 4 never sets.
  always_comb
  begin
    flag_set = '0;
    flag_set[`MDS_ST_RX_DESC_UNAV] = rx_run && rx_desc_fetch_fail;
    flag_set[`MDS_ST_RX_COMPLETE]  = rx_frame_done;
    flag_set[`MDS_ST_TX_UNDERFLOW] = tx_run && tx_underflow;
    flag_set[`MDS_ST_TX_JABBER]    = tx_run && tx_jabber_expire;
    flag_set[`MDS_ST_TX_DESC_UNAV] = tx_run && tx_desc_fetch_fail;
    flag_set[`MDS_ST_TX_STOPPED]   =
      (tx_state_ff == mds_pkg::MDS_PROC_STOP);
    flag_set[`MDS_ST_TX_COMPLETE]  =
      tx_frame_done && tx_desc_word1[`MDS_TDW1_IRQ_REQ];
  end

  // Software clears a flag by writing a one to its position.
  assign flag_clr = wr_status ? reg_wdata[`MDS_FLAG_W-1:0]
                              : {`MDS_FLAG_W{1'b0}};

  // Sticky status flags.
  mds_flag_bank u_flags
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set_evt (flag_set),
    .clr_req (flag_clr),
    .flags   (flags)
  );

  // Summary bits follow the flags directly and need no clearing of their own.
  assign normal_summary_flag = flags[`MDS_ST_TX_COMPLETE]
                            || flags[`MDS_ST_TX_DESC_UNAV]
                            || flags[`MDS_ST_RX_COMPLETE];
  assign abnormal_summary_flag = flags[`MDS_ST_TX_STOPPED]
                              || flags[`MDS_ST_TX_JABBER]
                              || flags[`MDS_ST_TX_UNDERFLOW]
                              || flags[`MDS_ST_RX_DESC_UNAV]
                              || ext_abnormal;

  // Network access control bits.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sf_ff      <= `MDS_NAC_SF_RESET;
      sqe_dis_ff <= `MDS_NAC_SQE_RESET;
    end
    else if (wr_nac)
    begin
      sf_ff      <= reg_wdata[`MDS_NAC_STORE_FWD];
      sqe_dis_ff <= reg_wdata[`MDS_NAC_SQE_DISABLE];
    end
  end

  // Interrupt mask, same layout as the low status bits.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_ff <= `MDS_MASK_RESET;
    else if (wr_mask)
      mask_ff <= reg_wdata[`MDS_FLAG_W-1:0];
  end

  // Poll demands are one-cycle pulses towards the descriptor engines.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_poll_ff <= 1'b0;
      tx_poll_ff <= 1'b0;
    end
    else
    begin
      rx_poll_ff <= wr_rx_poll;
      tx_poll_ff <= wr_tx_poll;
    end
  end

  // Receive process: a missing descriptor suspends it, and either a
  // poll demand or a newly recognized frame brings it back.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_state_ff <= mds_pkg::MDS_PROC_STOP;
    else
    begin
      unique case (rx_state_ff)
        mds_pkg::MDS_PROC_STOP:
          if (rx_start_cmd)
            rx_state_ff <= mds_pkg::MDS_PROC_RUN;
        mds_pkg::MDS_PROC_RUN:
          if (rx_stop_cmd)
            rx_state_ff <= mds_pkg::MDS_PROC_STOP;
          else if (rx_desc_fetch_fail)
            rx_state_ff <= mds_pkg::MDS_PROC_SUSPEND;
        mds_pkg::MDS_PROC_SUSPEND:
          if (rx_stop_cmd)
            rx_state_ff <= mds_pkg::MDS_PROC_STOP;
          else if (wr_rx_poll || rx_frame_recognized)
            rx_state_ff <= mds_pkg::MDS_PROC_RUN;
        default:
          rx_state_ff <= mds_pkg::MDS_PROC_STOP;
      endcase
    end
  end

  // Transmit process: jabber stops it and beats the other events in the
  // same cycle; underflow or a missing descriptor suspends it. The host
  // hands the descriptor back before it polls, so a poll simply resumes.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_state_ff <= mds_pkg::MDS_PROC_STOP;
    else
    begin
      unique case (tx_state_ff)
        mds_pkg::MDS_PROC_STOP:
          if (tx_start_cmd)
            tx_state_ff <= mds_pkg::MDS_PROC_RUN;
        mds_pkg::MDS_PROC_RUN:
          if (tx_jabber_expire || tx_stop_cmd)
            tx_state_ff <= mds_pkg::MDS_PROC_STOP;
          else if (tx_underflow)
            tx_state_ff <= mds_pkg::MDS_PROC_SUSPEND;
          else if (tx_desc_fetch_fail)
            tx_state_ff <= mds_pkg::MDS_PROC_SUSPEND;
        mds_pkg::MDS_PROC_SUSPEND:
          if (tx_stop_cmd)
            tx_state_ff <= mds_pkg::MDS_PROC_STOP;
          else if (wr_tx_poll || tx_auto_poll)
            tx_state_ff <= mds_pkg::MDS_PROC_RUN;
        default:
          tx_state_ff <= mds_pkg::MDS_PROC_STOP;
      endcase
    end
  end

  // Write-back of the first transmit descriptor word on an error.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tdw0_wr_ff <= 1'b0;
      tdw0_ff    <= 32'h0000_0000;
    end
    else
    begin
      tdw0_wr_ff <= tx_run && (tx_underflow || tx_jabber_expire);
      if (tx_run && (tx_underflow || tx_jabber_expire))
      begin
        tdw0_ff <= 32'h0000_0000;
        tdw0_ff[`MDS_TDW0_UNDERFLOW] <= tx_underflow;
        tdw0_ff[`MDS_TDW0_JABBER]    <= tx_jabber_expire;
      end
    end
  end

  // Start of transmission: store and forward waits for the whole frame
  // and ignores the threshold reached signal.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_begin_ff <= 1'b0;
    else
      tx_begin_ff <= tx_run
                  && (sf_ff ? tx_frame_whole : tx_threshold_met);
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    reg_rdata = 32'h0000_0000;
    if (reg_hit(reg_addr, `MDS_STATUS_OFF))
    begin
      reg_rdata[`MDS_FLAG_W-1:0]     = flags;
      reg_rdata[`MDS_ST_RESERVED4]   = 1'b0;
      reg_rdata[`MDS_ST_ABN_SUMMARY] = abnormal_summary_flag;
      reg_rdata[`MDS_ST_NRM_SUMMARY] = normal_summary_flag;
    end
    else if (reg_hit(reg_addr, `MDS_NAC_OFF))
    begin
      reg_rdata[`MDS_NAC_STORE_FWD]   = sf_ff;
      reg_rdata[`MDS_NAC_SQE_DISABLE] = sqe_dis_ff;
    end
    else if (reg_hit(reg_addr, `MDS_MASK_OFF))
      reg_rdata[`MDS_FLAG_W-1:0] = mask_ff;
  end

  // Outputs towards the engines and the interrupt controller.
  assign rx_state             = rx_state_ff;
  assign tx_state             = tx_state_ff;
  assign rx_poll_demand       = rx_poll_ff;
  assign tx_poll_demand       = tx_poll_ff;
  assign tx_begin             = tx_begin_ff;
  assign tx_desc_word0_wr     = tdw0_wr_ff;
  assign tx_desc_word0        = tdw0_ff;
  assign store_forward_enable = sf_ff;
  assign sqe_test_enable      = !sqe_dis_ff;
  assign irq                  = |(flags & mask_ff);

endmodule // mds_status_top

/* tb/mds_status_assertions.sv */
// Concurrent checks on the ports of the status block.
`timescale 1ns/1ns

module mds_status_assertions
(
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus handshake.
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Engine events.
  input wire logic        rx_stop_cmd,
  input wire logic        rx_desc_fetch_fail,
  input wire logic        rx_frame_recognized,
  input wire logic        tx_stop_cmd,
  input wire logic        tx_desc_fetch_fail,
  input wire logic        tx_underflow,
  input wire logic        tx_jabber_expire,
  input wire logic        tx_frame_whole,
  // Process outputs.
  input wire logic [1:0]  rx_state,
  input wire logic [1:0]  tx_state,
  input wire logic        tx_begin,
  input wire logic        tx_desc_word0_wr,
  input wire logic [31:0] tx_desc_word0,
  input wire logic        store_forward_enable
);
  // All checks run on the bus clock and rest during reset.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Decoded process states and a taken word read.
  wire tx_run  = tx_state == mds_pkg::MDS_PROC_RUN;
  wire tx_susp = tx_state == mds_pkg::MDS_PROC_SUSPEND;
  wire tx_stop = tx_state == mds_pkg::MDS_PROC_STOP;
  wire rx_run  = rx_state == mds_pkg::MDS_PROC_RUN;
  wire rx_susp = rx_state == mds_pkg::MDS_PROC_SUSPEND;
  wire rd_req  = hsel && hready && htrans[1] && !hwrite && hsize == 3'b010;
  wire sf_run  = store_forward_enable && tx_run;

  uf_suspend_a: assert property (
    tx_run && tx_underflow && !tx_jabber_expire && !tx_stop_cmd |=>
    tx_susp && tx_desc_word0_wr && tx_desc_word0[1])
    else $error("Underflow did not suspend transmit.");
  wr_cause_a: assert property (
    tx_desc_word0_wr |-> $past(tx_underflow) || $past(tx_jabber_expire))
    else $error("Descriptor written back without a cause.");
  jab_stop_a: assert property (
    tx_run && tx_jabber_expire |=>
    tx_stop && tx_desc_word0_wr && tx_desc_word0[14])
    else $error("Jabber expiry did not stop transmit.");
  txdu_susp_a: assert property (
    tx_run && tx_desc_fetch_fail && !tx_underflow && !tx_jabber_expire &&
    !tx_stop_cmd |=> tx_susp)
    else $error("Missing transmit descriptor did not suspend.");
  rxdu_susp_a: assert property (
    rx_run && rx_desc_fetch_fail && !rx_stop_cmd |=> rx_susp)
    else $error("Missing receive descriptor did not suspend.");
  rx_resume_a: assert property (
    rx_susp && rx_frame_recognized && !rx_stop_cmd |=> rx_run)
    else $error("Recognized frame did not resume receive.");
  sf_begin_a: assert property (
    (sf_run && $stable(tx_frame_whole)) [*2] |-> tx_begin == tx_frame_whole)
    else $error("Store and forward start not tied to whole frame.");
  rd_wait_a: assert property (
    rd_req |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state is not one cycle.");

  // Main scenarios reached by the bench.
  cover property (tx_run && tx_underflow);
  cover property (tx_desc_word0_wr && tx_desc_word0[14]);
  cover property (rx_susp ##1 rx_run);
endmodule // mds_status_assertions

bind mds_status_top mds_status_assertions u_chk
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .rx_stop_cmd(rx_stop_cmd), .rx_desc_fetch_fail(rx_desc_fetch_fail),
  .rx_frame_recognized(rx_frame_recognized), .tx_stop_cmd(tx_stop_cmd),
  .tx_desc_fetch_fail(tx_desc_fetch_fail), .tx_underflow(tx_underflow),
  .tx_jabber_expire(tx_jabber_expire), .tx_frame_whole(tx_frame_whole),
  .rx_state(rx_state), .tx_state(tx_state), .tx_begin(tx_begin),
  .tx_desc_word0_wr(tx_desc_word0_wr), .tx_desc_word0(tx_desc_word0),
  .store_forward_enable(store_forward_enable)
);

/* tb/mds_desc_model.sv */
// Behavioural first transmit descriptor beside the status block.
`timescale 1ns/1ns

module mds_desc_model
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Write back of descriptor word0 from the block.
  input  wire logic        word0_wr,
  input  wire logic [31:0] word0,
  // Completion request the host placed in word1.
  input  wire logic        irq_req,
  output logic      [31:0] word1,
  output logic      [31:0] word0_ff
);
  // Only the top bit requests completion; the rest is filler.
  assign word1 = {irq_req, 31'h0000_0a5c};

  // Keeps the status word last written back by the block.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      word0_ff <= 32'h0;
    else if (word0_wr)
      word0_ff <= word0;
endmodule // mds_desc_model

/* tb/mds_status_tb.sv */
// Self-checking bench for the status block over its register bus.
`timescale 1ns/1ns
`include "mds_regs.svh"

module mac_dma_status_and_netaccess_bits_tb_top;
  // Compares a design value with its expectation.
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    num_errors++; $display("ERROR %0t: got %h expected %h", $time, a, b); \
    end end

  // Bus master, event pulses and levels (threshold, whole, ext, request).
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'b010;
  logic [31:0] hwdata  = 32'h0;
  logic [11:0] ev      = 12'h0;
  logic [3:0]  lv      = 4'h0;
  logic [31:0] q;
  logic [31:0] hrdata, w0, w1, w0_ff;
  logic [1:0]  rx_st, tx_st;
  logic        hreadyout, irq, tx_begin, w0_wr, sfe, sqe;
  logic        hresp_o, rx_pd, tx_pd;
  int          num_errors  = 0;
  int          comparisons = 0;

  // Bus clock of 4 ns.
  always #2 hclk = ~hclk;

  mds_status_top uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp_o),
    .hrdata(hrdata),
    .rx_start_cmd(ev[0]), .rx_stop_cmd(ev[1]), .rx_desc_fetch_fail(ev[2]),
    .rx_frame_done(ev[3]), .rx_frame_recognized(ev[4]),
    .tx_start_cmd(ev[5]), .tx_stop_cmd(ev[6]), .tx_auto_poll(ev[7]),
    .tx_desc_fetch_fail(ev[8]), .tx_underflow(ev[9]),
    .tx_jabber_expire(ev[10]), .tx_frame_done(ev[11]), .tx_desc_word1(w1),
    .tx_threshold_met(lv[0]), .tx_frame_whole(lv[1]), .ext_abnormal(lv[2]),
    .rx_state(rx_st), .tx_state(tx_st), .rx_poll_demand(rx_pd),
    .tx_poll_demand(tx_pd), .tx_begin(tx_begin), .tx_desc_word0_wr(w0_wr),
    .tx_desc_word0(w0), .store_forward_enable(sfe),
    .sqe_test_enable(sqe), .irq(irq)
  );

  mds_desc_model u_desc
  (
    .hclk(hclk), .hresetn(hresetn), .word0_wr(w0_wr), .word0(w0),
    .irq_req(lv[3]), .word1(w1), .word0_ff(w0_ff)
  );

  // Waits for hready high at a rising edge, keeping the settled read data.
  task automatic wait_rdy();
    do
    begin
      @(negedge hclk);
      q = hrdata;
    end
    while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask

  // One single-word transfer: address phase, then data phase.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    @(negedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  // Expected status word from the flag bits and the outside abnormal level.
  function automatic logic [31:0] exps(input logic [7:0] f);
    logic [31:0] r;
    r     = {24'h0, f};
    r[15] = |(f & 8'haa) | lv[2];
    r[16] = |(f & 8'h45);
    return r;
  endfunction

  task automatic chk_st(input logic [7:0] f);
    rd(`MDS_STATUS_OFF, exps(f));
  endtask

  // One-cycle event pulse, then a settled point to look at outputs.
  task automatic pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev[i] <= 1'b0;
    @(negedge hclk);
  endtask

  // Level change, then two edges for registered outputs to follow.
  task automatic set_lv(input int i, input logic v);
    @(posedge hclk);
    lv[i] <= v;
    repeat (2) @(negedge hclk);
  endtask

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well after the sequence should end.
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    conclude();
  end

  // Register reset values, sticky flags, process states and control bits.
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK({sfe, sqe}, 2'b00)
    rd(`MDS_NAC_OFF, 32'h0008_0000);
    rd(`MDS_MASK_OFF, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0);
    chk_st(8'h02);
    wr(`MDS_STATUS_OFF, 32'h2);
    chk_st(8'h02);
    wr(`MDS_MASK_OFF, 32'h1);
    `CHK(irq, 1'b0)
    wr(`MDS_MASK_OFF, 32'h2);
    `CHK(irq, 1'b1)
    rd(`MDS_MASK_OFF, 32'h2);
    pulse(5);
    `CHK(tx_st, mds_pkg::MDS_PROC_RUN)
    wr(`MDS_STATUS_OFF, 32'h2);
    `CHK(irq, 1'b0)
    pulse(11);
    chk_st(8'h00);
    set_lv(3, 1'b1);
    pulse(11);
    chk_st(8'h01);
    wr(`MDS_STATUS_OFF, 32'h0);
    chk_st(8'h01);
    pulse(9);
    `CHK(tx_st, mds_pkg::MDS_PROC_SUSPEND)
    `CHK({w0_wr, w0[1], w0[14]}, 3'b110)
    @(negedge hclk);
    `CHK(w0_ff[1], 1'b1)
    pulse(8);
    chk_st(8'h21);
    wr(`MDS_TX_POLL_OFF, 32'h0);
    `CHK({hresp_o, tx_pd}, 2'b01)
    `CHK(tx_st, mds_pkg::MDS_PROC_RUN)
    pulse(8);
    `CHK(tx_st, mds_pkg::MDS_PROC_SUSPEND)
    chk_st(8'h25);
    pulse(7);
    `CHK(tx_st, mds_pkg::MDS_PROC_RUN)
    wr(`MDS_STATUS_OFF, 32'hff);
    pulse(10);
    `CHK(tx_st, mds_pkg::MDS_PROC_STOP)
    `CHK({w0_wr, w0[14], w0[1]}, 3'b110)
    @(negedge hclk);
    `CHK(w0_ff[14], 1'b1)
    chk_st(8'h0a);
    pulse(0);
    pulse(3);
    chk_st(8'h4a);
    pulse(2);
    `CHK(rx_st, mds_pkg::MDS_PROC_SUSPEND)
    chk_st(8'hca);
    wr(`MDS_RX_POLL_OFF, 32'h0);
    `CHK(rx_pd, 1'b1)
    `CHK(rx_st, mds_pkg::MDS_PROC_RUN)
    pulse(2);
    pulse(4);
    `CHK(rx_st, mds_pkg::MDS_PROC_RUN)
    wr(`MDS_NAC_OFF, 32'h0020_0000);
    rd(`MDS_NAC_OFF, 32'h0020_0000);
    `CHK({sfe, sqe}, 2'b11)
    pulse(5);
    set_lv(0, 1'b1);
    `CHK(tx_begin, 1'b0)
    set_lv(1, 1'b1);
    `CHK(tx_begin, 1'b1)
    wr(`MDS_NAC_OFF, 32'h0008_0000);
    set_lv(1, 1'b0);
    `CHK(tx_begin, 1'b1)
    wr(`MDS_STATUS_OFF, 32'hff);
    set_lv(2, 1'b1);
    chk_st(8'h00);
    conclude();
  end
endmodule // mac_dma_status_and_netaccess_bits_tb_top
